// ===== pkg/smmc_pkg.sv
// Behaviour
// - Forward sweep command drives inverted sweep control.
// - Host waits six encoder pulses before reading.
// - Host swaps forward sweep for stop at coordinate.
// - Stopped indication rises 8 ms after stop.
// - Stopped indication also quiets the servo amplifier.
// - Host starts flyback only once mirror stopped.
// - Reverse ramp raises integrator release and ramp-up.
// - Host ends reverse ramp at switching coordinate.
// - Ramp end swaps ramp-up for ramp-down.
// - Comparator fall during ramp-down holds velocity.
// - Stop in flyback disables the integrator.
// - Flyback stop gives the same delayed indication.
// - Encoder direction pulses are relayed to host.
// - Read-area gate is relayed, high inside area.
// - Coordinates run 00 to ff, reversed in image.
// - Image select inverts servo and tachometer polarity.
// - Sweep correction carries five-bit velocity error.
// - Overspeed faults reported as separate signals.
// - Commands blocked at power-on, autoload, overspeed.
// - Homing ramps up until comparator rises.
// - Host stops homing when gate falls.
package smmc_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int STOP_DELAY_NS = 8_000_000;
    localparam int STOP_DELAY_CYC = STOP_DELAY_NS / CLK_PERIOD_NS;
    localparam int SETTLE_PULSES = 6;
    localparam int VERR_W = 5;
    localparam logic [7:0] COORD_FIRST = 8'h00;
    localparam logic [7:0] COORD_LAST = 8'hff;
    // Host register offsets
    localparam logic [11:0] REG_CMD = 12'h000;
    localparam logic [11:0] REG_STOP_COORD = 12'h004;
    localparam logic [11:0] REG_SWITCH_COORD = 12'h008;
    localparam logic [11:0] REG_CFG = 12'h00c;
    localparam logic [11:0] REG_STATUS = 12'h010;
    // Command codes written to REG_CMD
    localparam logic [2:0] CODE_SCAN = 3'h1;
    localparam logic [2:0] CODE_FLYBACK = 3'h2;
    localparam logic [2:0] CODE_HOME = 3'h3;
    localparam logic [2:0] CODE_STOP = 3'h4;
    localparam int STAT_STOPPED_BIT = 8;
    localparam int STAT_GATE_BIT = 9;
    localparam int STAT_READY_BIT = 10;
    typedef enum logic [6:0] {
        ST_STOP = 7'h01,
        ST_SCAN = 7'h02,
        ST_FLY_ACC = 7'h04,
        ST_FLY_DEC = 7'h08,
        ST_FLY_HOLD = 7'h10,
        ST_HOME_ACC = 7'h20,
        ST_HOME_HOLD = 7'h40
    } smmc_dev_state_t;
    typedef enum logic [5:0] {
        H_IDLE = 6'h01,
        H_SCAN = 6'h02,
        H_FLY = 6'h04,
        H_COAST = 6'h08,
        H_HOME = 6'h10,
        H_STOP = 6'h20
    } smmc_host_state_t;
endpackage

// ===== pkg/smmc_if.sv
`timescale 1ns/1ps
interface smmc_if;
    logic cmd_scan;
    logic cmd_flyback;
    logic cmd_home;
    logic cmd_stop;
    logic mirror_stopped_indication;
    logic scan_gate;
    logic fwd_pulse;
    logic rev_pulse;
    modport dev (
        input cmd_scan, cmd_flyback, cmd_home, cmd_stop,
        output mirror_stopped_indication, scan_gate, fwd_pulse, rev_pulse
    );
    modport host_controller (
        output cmd_scan, cmd_flyback, cmd_home, cmd_stop,
        input mirror_stopped_indication, scan_gate, fwd_pulse, rev_pulse
    );
endinterface

// ===== src/smmc_device.sv
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
module smmc_device #(
    parameter int STOP_CYC = smmc_pkg::STOP_DELAY_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Host link
    smmc_if.dev lnk,
    // Encoder and comparator pins
    input wire logic enc_fwd_pulse,
    input wire logic enc_rev_pulse,
    input wire logic enc_scan_gate,
    input wire logic reverse_velocity_reached,
    input wire logic overspeed_fwd,
    input wire logic overspeed_rev,
    // System conditions
    input wire logic power_on_seq,
    input wire logic autoload_seq,
    input wire logic fault_reset,
    input wire logic mirror_image_select,
    // Velocity error from error detection logic
    input wire logic [smmc_pkg::VERR_W-1:0] vel_err,
    // Drive command controls
    output logic sweep_forward_n,
    output logic flyback_disable,
    output logic flyback_accel,
    output logic flyback_decel,
    output logic [smmc_pkg::VERR_W-1:0] sweep_corr,
    // Servo amplifier controls
    output logic servo_quiet,
    output logic servo_invert,
    output logic tach_invert,
    // Fault reports
    output logic overspeed_fwd_fault,
    output logic overspeed_rev_fault
);
    localparam int NSYNC = 10;
    localparam int SI_FWD = 0;
    localparam int SI_REV = 1;
    localparam int SI_GATE = 2;
    localparam int SI_RMV = 3;
    localparam int SI_OVF = 4;
    localparam int SI_OVR = 5;
    localparam int SI_PON = 6;
    localparam int SI_AUTO = 7;
    localparam int SI_FRST = 8;
    localparam int SI_IMG = 9;

    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic rmv_prev;
    logic rmv_rise;
    logic rmv_fall;
    logic blocked;
    logic fault_fwd;
    logic fault_rev;
    logic [31:0] stop_cnt;
    logic stop_done;
    smmc_pkg::smmc_dev_state_t state;

    assign pin_raw = {mirror_image_select, fault_reset, autoload_seq, power_on_seq,
                      overspeed_rev, overspeed_fwd, reverse_velocity_reached,
                      enc_scan_gate, enc_rev_pulse, enc_fwd_pulse};

    // Two-stage synchronisers for the ten single-bit encoder, comparator and system pins
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= pin_raw[gi];
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    // Comparator edge detection
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rmv_prev <= 1'b0;
        end else begin
            rmv_prev <= sync_b[SI_RMV];
        end
    end

    assign rmv_rise = sync_b[SI_RMV] & ~rmv_prev;
    assign rmv_fall = ~sync_b[SI_RMV] & rmv_prev;

    // Overspeed latches; a new overspeed beats a simultaneous reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fault_fwd <= 1'b0;
            fault_rev <= 1'b0;
        end else begin
            if (sync_b[SI_OVF]) begin
                fault_fwd <= 1'b1;
            end else if (sync_b[SI_FRST]) begin
                fault_fwd <= 1'b0;
            end
            if (sync_b[SI_OVR]) begin
                fault_rev <= 1'b1;
            end else if (sync_b[SI_FRST]) begin
                fault_rev <= 1'b0;
            end
        end
    end

    assign blocked = sync_b[SI_PON] | sync_b[SI_AUTO] | fault_fwd | fault_rev;

    // Motion sequencer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= smmc_pkg::ST_STOP;
        end else if (blocked) begin
            state <= smmc_pkg::ST_STOP;
        end else begin
            unique case (state)
                smmc_pkg::ST_STOP: begin
                    if (lnk.cmd_scan) begin
                        state <= smmc_pkg::ST_SCAN;
                    end else if (lnk.cmd_flyback) begin
                        state <= smmc_pkg::ST_FLY_ACC;
                    end else if (lnk.cmd_home) begin
                        state <= smmc_pkg::ST_HOME_ACC;
                    end
                end
                smmc_pkg::ST_SCAN: begin
                    if (!lnk.cmd_scan || lnk.cmd_stop) begin
                        state <= smmc_pkg::ST_STOP;
                    end
                end
                smmc_pkg::ST_FLY_ACC: begin
                    if (lnk.cmd_stop) begin
                        state <= smmc_pkg::ST_STOP;
                    end else if (!lnk.cmd_flyback) begin
                        state <= smmc_pkg::ST_FLY_DEC;
                    end
                end
                smmc_pkg::ST_FLY_DEC: begin
                    if (lnk.cmd_stop) begin
                        state <= smmc_pkg::ST_STOP;
                    end else if (rmv_fall) begin
                        state <= smmc_pkg::ST_FLY_HOLD;
                    end
                end
                smmc_pkg::ST_FLY_HOLD: begin
                    if (lnk.cmd_stop) begin
                        state <= smmc_pkg::ST_STOP;
                    end
                end
                smmc_pkg::ST_HOME_ACC: begin
                    if (lnk.cmd_stop) begin
                        state <= smmc_pkg::ST_STOP;
                    end else if (rmv_rise) begin
                        state <= smmc_pkg::ST_HOME_HOLD;
                    end
                end
                smmc_pkg::ST_HOME_HOLD: begin
                    if (lnk.cmd_stop) begin
                        state <= smmc_pkg::ST_STOP;
                    end
                end
                default: begin
                    state <= smmc_pkg::ST_STOP;
                end
            endcase
        end
    end

    // Stop delay, restarted by any motion
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stop_cnt <= 32'h0000_0000;
        end else if (state != smmc_pkg::ST_STOP) begin
            stop_cnt <= 32'h0000_0000;
        end else if (!stop_done) begin
            stop_cnt <= stop_cnt + 32'h0000_0001;
        end
    end

    assign stop_done = (stop_cnt >= 32'(STOP_CYC));

    // Indication to host and servo amplifier
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lnk.mirror_stopped_indication <= 1'b0;
            servo_quiet <= 1'b0;
        end else begin
            lnk.mirror_stopped_indication <= stop_done;
            servo_quiet <= stop_done;
        end
    end

    // Waveform generator controls
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sweep_forward_n <= 1'b1;
            flyback_disable <= 1'b1;
            flyback_accel <= 1'b0;
            flyback_decel <= 1'b0;
            sweep_corr <= '0;
        end else begin
            sweep_forward_n <= ~(state == smmc_pkg::ST_SCAN);
            flyback_disable <= (state == smmc_pkg::ST_STOP) ||
                               (state == smmc_pkg::ST_SCAN);
            flyback_accel <= (state == smmc_pkg::ST_FLY_ACC) ||
                             (state == smmc_pkg::ST_HOME_ACC);
            flyback_decel <= (state == smmc_pkg::ST_FLY_DEC);
            sweep_corr <= (state == smmc_pkg::ST_SCAN) ? vel_err : '0;
        end
    end

    // Polarity selection and fault reports
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            servo_invert <= 1'b0;
            tach_invert <= 1'b0;
            overspeed_fwd_fault <= 1'b0;
            overspeed_rev_fault <= 1'b0;
        end else begin
            servo_invert <= sync_b[SI_IMG];
            tach_invert <= sync_b[SI_IMG];
            overspeed_fwd_fault <= fault_fwd;
            overspeed_rev_fault <= fault_rev;
        end
    end

    // Encoder relay toward the host
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lnk.fwd_pulse <= 1'b0;
            lnk.rev_pulse <= 1'b0;
            lnk.scan_gate <= 1'b0;
        end else begin
            lnk.fwd_pulse <= sync_b[SI_FWD];
            lnk.rev_pulse <= sync_b[SI_REV];
            lnk.scan_gate <= sync_b[SI_GATE];
        end
    end
endmodule // smmc_device

// ===== src/smmc_host.sv
`timescale 1ns/1ps
module smmc_host (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Mirror link
    smmc_if.host_controller lnk,
    // Read start strobe
    output logic read_go
);
    smmc_pkg::smmc_host_state_t state;
    logic [7:0] stop_coord;
    logic [7:0] switch_coord;
    logic image;
    logic [7:0] pos;
    logic [2:0] settle_cnt;
    logic read_ready;
    logic fwd_prev;
    logic rev_prev;
    logic gate_prev;
    logic up_edge;
    logic down_edge;
    logic wr;
    logic mapped;
    logic [2:0] code;

    assign wr = psel & penable & pwrite & pready;
    assign code = pwdata[2:0];
    assign mapped = (paddr == smmc_pkg::REG_CMD) || (paddr == smmc_pkg::REG_STOP_COORD) ||
                    (paddr == smmc_pkg::REG_SWITCH_COORD) || (paddr == smmc_pkg::REG_CFG) ||
                    (paddr == smmc_pkg::REG_STATUS);
    assign up_edge = image ? (lnk.rev_pulse & ~rev_prev) : (lnk.fwd_pulse & ~fwd_prev);
    assign down_edge = image ? (lnk.fwd_pulse & ~fwd_prev) : (lnk.rev_pulse & ~rev_prev);

    // APB answer: ready in the first access cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            unique case (paddr)
                smmc_pkg::REG_CMD: prdata <= {26'h000_0000, state};
                smmc_pkg::REG_STOP_COORD: prdata <= {24'h00_0000, stop_coord};
                smmc_pkg::REG_SWITCH_COORD: prdata <= {24'h00_0000, switch_coord};
                smmc_pkg::REG_CFG: prdata <= {31'h0000_0000, image};
                smmc_pkg::REG_STATUS: prdata <= {21'h00_0000, read_ready, lnk.scan_gate,
                                                 lnk.mirror_stopped_indication, pos};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Coordinate registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stop_coord <= smmc_pkg::COORD_LAST;
            switch_coord <= smmc_pkg::COORD_FIRST;
            image <= 1'b0;
        end else if (wr) begin
            if (paddr == smmc_pkg::REG_STOP_COORD) begin
                stop_coord <= pwdata[7:0];
            end
            if (paddr == smmc_pkg::REG_SWITCH_COORD) begin
                switch_coord <= pwdata[7:0];
            end
            if (paddr == smmc_pkg::REG_CFG) begin
                image <= pwdata[0];
            end
        end
    end

    // Encoder edges and position, cleared outside the read area
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fwd_prev <= 1'b0;
            rev_prev <= 1'b0;
            gate_prev <= 1'b0;
            pos <= smmc_pkg::COORD_FIRST;
        end else begin
            fwd_prev <= lnk.fwd_pulse;
            rev_prev <= lnk.rev_pulse;
            gate_prev <= lnk.scan_gate;
            if (!lnk.scan_gate) begin
                pos <= smmc_pkg::COORD_FIRST;
            end else if (up_edge) begin
                pos <= pos + 8'h01;
            end else if (down_edge) begin
                pos <= pos - 8'h01;
            end
        end
    end

    // Sequencer; one command at a time
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= smmc_pkg::H_IDLE;
        end else begin
            unique case (state)
                smmc_pkg::H_IDLE: begin
                    if (wr && paddr == smmc_pkg::REG_CMD) begin
                        if (code == smmc_pkg::CODE_SCAN) begin
                            state <= smmc_pkg::H_SCAN;
                        end else if (code == smmc_pkg::CODE_FLYBACK &&
                                     lnk.mirror_stopped_indication) begin
                            state <= smmc_pkg::H_FLY;
                        end else if (code == smmc_pkg::CODE_HOME) begin
                            state <= smmc_pkg::H_HOME;
                        end else if (code == smmc_pkg::CODE_STOP) begin
                            state <= smmc_pkg::H_STOP;
                        end
                    end
                end
                smmc_pkg::H_SCAN: begin
                    if (pos == stop_coord && lnk.scan_gate) begin
                        state <= smmc_pkg::H_STOP;
                    end
                end
                smmc_pkg::H_FLY: begin
                    if (pos == switch_coord && lnk.scan_gate) begin
                        state <= smmc_pkg::H_COAST;
                    end
                end
                smmc_pkg::H_COAST: begin
                    if (pos == stop_coord) begin
                        state <= smmc_pkg::H_STOP;
                    end
                end
                smmc_pkg::H_HOME: begin
                    if (gate_prev && !lnk.scan_gate) begin
                        state <= smmc_pkg::H_STOP;
                    end
                end
                smmc_pkg::H_STOP: begin
                    state <= smmc_pkg::H_IDLE;
                end
                default: begin
                    state <= smmc_pkg::H_IDLE;
                end
            endcase
        end
    end

    // Command lines follow the state; stop stays up while idle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lnk.cmd_scan <= 1'b0;
            lnk.cmd_flyback <= 1'b0;
            lnk.cmd_home <= 1'b0;
            lnk.cmd_stop <= 1'b1;
        end else begin
            lnk.cmd_scan <= (state == smmc_pkg::H_SCAN);
            lnk.cmd_flyback <= (state == smmc_pkg::H_FLY);
            lnk.cmd_home <= (state == smmc_pkg::H_HOME);
            lnk.cmd_stop <= (state == smmc_pkg::H_STOP) || (state == smmc_pkg::H_IDLE);
        end
    end

    // Startup and settling wait before reading
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            settle_cnt <= 3'h0;
            read_ready <= 1'b0;
            read_go <= 1'b0;
        end else begin
            read_go <= 1'b0;
            if (state != smmc_pkg::H_SCAN) begin
                settle_cnt <= 3'h0;
                read_ready <= 1'b0;
            end else if (lnk.fwd_pulse && !fwd_prev && !read_ready) begin
                if (settle_cnt == 3'(smmc_pkg::SETTLE_PULSES - 1)) begin
                    read_ready <= 1'b1;
                    read_go <= 1'b1;
                end else begin
                    settle_cnt <= settle_cnt + 3'h1;
                end
            end
        end
    end
endmodule // smmc_host

// ===== testbench/smmc_properties.sv
`timescale 1ns/1ps
module smmc_properties #(
    parameter int STOP_CYC = 20
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Host commands
    input wire logic cmd_scan,
    input wire logic cmd_flyback,
    input wire logic cmd_home,
    input wire logic cmd_stop,
    // Device reports
    input wire logic mirror_stopped_indication,
    input wire logic scan_gate,
    input wire logic fwd_pulse,
    input wire logic rev_pulse
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    int stop_cnt;
    // Cycles spent with stop requested
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stop_cnt <= 0;
        end else if (!cmd_stop) begin
            stop_cnt <= 0;
        end else if (stop_cnt < 100000) begin
            stop_cnt <= stop_cnt + 1;
        end
    end
    property p_one_cmd;
        $onehot0({cmd_scan, cmd_flyback, cmd_home, cmd_stop});
    endproperty
    a_one_cmd: assert property (p_one_cmd) else $error("more than one command high");
    property p_motion_clears;
        (cmd_scan || cmd_flyback || cmd_home) [*4] |-> !mirror_stopped_indication;
    endproperty
    a_motion_clears: assert property (p_motion_clears) else $error("stopped during motion");
    property p_ind_delay;
        $rose(mirror_stopped_indication) |-> stop_cnt >= STOP_CYC && stop_cnt <= STOP_CYC + 4;
    endproperty
    a_ind_delay: assert property (p_ind_delay) else $error("stopped rose at wrong time");
    property p_ind_bound;
        stop_cnt == STOP_CYC + 5 |-> mirror_stopped_indication;
    endproperty
    a_ind_bound: assert property (p_ind_bound) else $error("stopped never rose");
    property p_fly_after_stop;
        $rose(cmd_flyback) |-> $past(mirror_stopped_indication, 2);
    endproperty
    a_fly_after_stop: assert property (p_fly_after_stop) else $error("flyback while moving");
    property p_scan_to_stop;
        $fell(cmd_scan) |-> cmd_stop;
    endproperty
    a_scan_to_stop: assert property (p_scan_to_stop) else $error("sweep ended without stop");
    property p_fly_coast;
        $fell(cmd_flyback) |-> !cmd_stop;
    endproperty
    a_fly_coast: assert property (p_fly_coast) else $error("ramp ended by stop");
    property p_home_gate;
        cmd_home && $fell(scan_gate) |-> ##[1:3] (!cmd_home && cmd_stop);
    endproperty
    a_home_gate: assert property (p_home_gate) else $error("homing not stopped at gate");
    c_scan: cover property ($rose(cmd_scan));
    c_fly: cover property ($rose(cmd_flyback));
    c_home: cover property ($rose(cmd_home));
    c_stopped: cover property ($rose(mirror_stopped_indication));
endmodule // smmc_properties

// ===== testbench/scan_mirror_motion_control_bench.sv
`timescale 1ns/1ps
module scan_mirror_motion_control_bench;
    localparam int SC = 20;
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, read_go, go_seen = 1'h0;
    logic efp = 1'h0, erp = 1'h0, egate = 1'h0, rvr = 1'h0, ovf = 1'h0, ovr = 1'h0;
    logic pon = 1'h0, aload = 1'h0, frst = 1'h0, img = 1'h0;
    logic [4:0] verr = 5'h0b, corr;
    logic sfn, fd, fa, fdc, quiet, sinv, tinv, of_f, or_f;
    logic d2_sfn, d2_fd, d2_fa, d2_fdc, d2_of, d2_or;
    int fail_count = 0, tests_run = 0, cyc = 0;
    smmc_if lnk ();
    smmc_if lnk2 ();
    smmc_host smmc_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .lnk(lnk.host_controller), .read_go(read_go));
    smmc_device #(.STOP_CYC(SC)) smmc_device_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .lnk(lnk.dev), .enc_fwd_pulse(efp), .enc_rev_pulse(erp), .enc_scan_gate(egate),
        .reverse_velocity_reached(rvr), .overspeed_fwd(ovf), .overspeed_rev(ovr),
        .power_on_seq(pon), .autoload_seq(aload), .fault_reset(frst), .mirror_image_select(img),
        .vel_err(verr), .sweep_forward_n(sfn), .flyback_disable(fd), .flyback_accel(fa),
        .flyback_decel(fdc), .sweep_corr(corr), .servo_quiet(quiet), .servo_invert(sinv),
        .tach_invert(tinv), .overspeed_fwd_fault(of_f), .overspeed_rev_fault(or_f));
    smmc_device #(.STOP_CYC(SC)) smmc_device_inst_b (.clk_sys(clk_sys), .rst_n(rst_n),
        .lnk(lnk2.dev), .enc_fwd_pulse(efp), .enc_rev_pulse(erp), .enc_scan_gate(egate),
        .reverse_velocity_reached(rvr), .overspeed_fwd(ovf), .overspeed_rev(ovr),
        .power_on_seq(pon), .autoload_seq(aload), .fault_reset(frst), .mirror_image_select(img),
        .vel_err(verr), .sweep_forward_n(d2_sfn), .flyback_disable(d2_fd), .flyback_accel(d2_fa),
        .flyback_decel(d2_fdc), .sweep_corr(), .servo_quiet(), .servo_invert(),
        .tach_invert(), .overspeed_fwd_fault(d2_of), .overspeed_rev_fault(d2_or));
    smmc_properties #(.STOP_CYC(SC)) smmc_properties_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .cmd_scan(lnk.cmd_scan), .cmd_flyback(lnk.cmd_flyback), .cmd_home(lnk.cmd_home),
        .cmd_stop(lnk.cmd_stop), .mirror_stopped_indication(lnk.mirror_stopped_indication),
        .scan_gate(lnk.scan_gate), .fwd_pulse(lnk.fwd_pulse), .rev_pulse(lnk.rev_pulse));
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (read_go === 1'h1) go_seen <= 1'h1;
        if (cyc == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'h1; penable <= 1'h0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        do @(posedge clk_sys); while (pready !== 1'h1);
        q = prdata;
        err = pslverr;
        psel <= 1'h0; penable <= 1'h0;
    endtask
    task automatic rpt(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wstop;
        int n;
        n = 0;
        while (lnk.mirror_stopped_indication !== 1'h1 && n < 200) begin
            @(posedge clk_sys);
            n++;
        end
        rpt(4);
    endtask
    initial begin
        lnk2.cmd_scan = 1'h0; lnk2.cmd_flyback = 1'h0; lnk2.cmd_home = 1'h0; lnk2.cmd_stop = 1'h1;
        rpt(8);
        rst_n <= 1'h1;
        apb(1'h0, smmc_pkg::REG_STOP_COORD, 32'h0); chk(q, 32'h0000_00ff);
        apb(1'h0, smmc_pkg::REG_SWITCH_COORD, 32'h0); chk(q, 32'h0);
        apb(1'h0, 12'h100, 32'h0); chk(q, 32'h0); chkb(err, 1'h1);
        wstop(); chkb(sfn, 1'h1); chkb(fd, 1'h1); chkb(quiet, 1'h1);
        egate <= 1'h1;
        apb(1'h1, smmc_pkg::REG_STOP_COORD, 32'h8);
        apb(1'h1, smmc_pkg::REG_CMD, {29'h0, smmc_pkg::CODE_SCAN}); rpt(6);
        chkb(sfn, 1'h0);
        chk({27'h0, corr}, {27'h0, verr});
        chkb(quiet, 1'h0); chkb(lnk.scan_gate, 1'h1);
        repeat (8) begin
            efp <= 1'h1; rpt(5); efp <= 1'h0; rpt(5);
        end
        chkb(go_seen, 1'h1);
        wstop(); chkb(sfn, 1'h1); chkb(quiet, 1'h1);
        apb(1'h0, smmc_pkg::REG_STATUS, 32'h0); chk({24'h0, q[7:0]}, 32'h8);
        apb(1'h1, smmc_pkg::REG_STOP_COORD, 32'h0); apb(1'h1, smmc_pkg::REG_SWITCH_COORD, 32'h4);
        apb(1'h1, smmc_pkg::REG_CMD, {29'h0, smmc_pkg::CODE_FLYBACK}); rpt(6);
        chkb(fd, 1'h0); chkb(fa, 1'h1);
        repeat (8) begin
            erp <= 1'h1; rpt(5); erp <= 1'h0; rpt(5);
        end
        chkb(fd, 1'h1); chkb(fa, 1'h0);
        wstop(); chkb(lnk.mirror_stopped_indication, 1'h1);
        efp <= 1'h1; erp <= 1'h1; rpt(5);
        chkb(lnk.fwd_pulse, 1'h1); chkb(lnk.rev_pulse, 1'h1);
        efp <= 1'h0; erp <= 1'h0; rpt(6);
        apb(1'h1, smmc_pkg::REG_CMD, {29'h0, smmc_pkg::CODE_HOME}); rpt(6);
        chkb(fa, 1'h1); chkb(fd, 1'h0);
        rvr <= 1'h1; rpt(6); chkb(fa, 1'h0);
        rvr <= 1'h0; egate <= 1'h0; rpt(8);
        chkb(lnk.cmd_home, 1'h0); chkb(fd, 1'h1);
        wstop();
        img <= 1'h1;
        apb(1'h1, smmc_pkg::REG_CFG, 32'h1); rpt(5);
        chkb(sinv, 1'h1); chkb(tinv, 1'h1);
        apb(1'h0, smmc_pkg::REG_CFG, 32'h0); chk(q, 32'h1);
        lnk2.cmd_stop <= 1'h0; lnk2.cmd_flyback <= 1'h1; rpt(4);
        chkb(d2_fa, 1'h1); chkb(d2_fd, 1'h0);
        lnk2.cmd_flyback <= 1'h0; rpt(4);
        chkb(d2_fa, 1'h0); chkb(d2_fdc, 1'h1);
        rvr <= 1'h1; rpt(6); rvr <= 1'h0; rpt(6);
        chkb(d2_fdc, 1'h0); chkb(d2_fd, 1'h0);
        lnk2.cmd_stop <= 1'h1; rpt(4); chkb(d2_fd, 1'h1);
        rpt(SC + 8); chkb(lnk2.mirror_stopped_indication, 1'h1);
        aload <= 1'h1; rpt(5);
        lnk2.cmd_stop <= 1'h0; lnk2.cmd_scan <= 1'h1; rpt(6); chkb(d2_sfn, 1'h1);
        lnk2.cmd_scan <= 1'h0; lnk2.cmd_stop <= 1'h1; aload <= 1'h0; rpt(6);
        ovf <= 1'h1; rpt(5); ovf <= 1'h0; rpt(5);
        chkb(d2_of, 1'h1); chkb(d2_or, 1'h0);
        lnk2.cmd_stop <= 1'h0; lnk2.cmd_scan <= 1'h1; rpt(6); chkb(d2_sfn, 1'h1);
        lnk2.cmd_scan <= 1'h0; lnk2.cmd_stop <= 1'h1;
        ovr <= 1'h1; rpt(5); ovr <= 1'h0; frst <= 1'h1; rpt(5); frst <= 1'h0; rpt(5);
        chkb(d2_of, 1'h0); chkb(d2_or, 1'h0);
        give_verdict();
    end
endmodule // scan_mirror_motion_control_bench
